// File: testbench.sv
// Self-checking bench for the host transmit endpoint block.
// Assumes the function device model stands at the packet engine side.
`timescale 1ns/1ps
module testbench
    import utx_pkg::*;
;
    logic clk, rst, cyc, stb, we, ack, go, slow, rx_pkt, busy, start, setup, tog, dir, dreq, prst, irq, lok, rirq;
    logic [7:0] adr;
    logic [31:0] dat, rdat, rnd;
    logic [3:0] sel, hs, cnt;
    logic [1:0] kind;
    logic [10:0] rx_len, lim;
    logic [31:0] exp_q[$];
    int n_mismatch, n_checks, n_irq, n_prst, n_ok, n_rxi, i0, p0;

    utx_ep_ctrl i_utx_ep_ctrl (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .dat_i(dat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .tx_ack_i(hs[0]), .tx_nak_i(hs[1]),
        .tx_no_hs_i(hs[2]), .tx_stall_i(hs[3]), .rx_pkt_i(rx_pkt), .rx_len_i(rx_len), .rx_crc_err_i(1'b0),
        .rx_store_fail_i(1'b0), .rx_full_i(1'b0), .rx_stall_sent_i(1'b0), .tx_start_o(start),
        .tx_setup_o(setup), .tx_toggle_o(tog), .tx_dir_o(dir), .tx_dma_req_o(dreq), .tx_ptr_rst_o(prst),
        .tx_irq_o(irq), .rx_len_ok_o(lok), .rx_irq_o(rirq), .rx_nyet_o(), .rx_stall_o(), .rx_toggle_o(),
        .rx_dma_req_o(), .rx_ptr_rst_o());
    utx_func_model i_utx_func_model (.clk_i(clk), .rst_i(rst), .start_i(start), .go_i(go), .kind_i(kind),
        .cnt_i(cnt), .slow_i(slow), .hs_o(hs), .busy_o(busy));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t read %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t output %h expected %h", $time, g, e);
        end
    endtask
    // Holds the request until ack is sampled; no fixed latency assumed
    task automatic wb(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, input logic w);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0000, d};
        sel <= s;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        wb(a, 16'h0000, 4'hf, 1'b0);
    endtask
    task automatic usb(input logic [1:0] k, input logic [3:0] n, input logic s);
        @(posedge clk);
        go <= 1'b1;
        kind <= k;
        cnt <= n;
        slow <= s;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy !== 1'b0);
        repeat (3) @(posedge clk);
    endtask
    task automatic pkt(input logic [10:0] l);
        @(posedge clk);
        rx_pkt <= 1'b1;
        rx_len <= l;
        @(posedge clk);
        rx_pkt <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            chk_rd(rdat, exp_q.pop_front());
        end
        if (rst === 1'b0) begin
            n_irq <= n_irq + int'(irq);
            n_prst <= n_prst + int'(prst);
            n_ok <= n_ok + int'(lok);
            n_rxi <= n_rxi + int'(rirq);
        end
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // About forty times what the sequence needs
    initial begin
        #200_000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        {cyc, stb, we, go, slow, rx_pkt} = 6'h00;
        {adr, dat, sel, kind, cnt, rx_len} = '0;
        rnd = 32'ha304b570;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_TX_CSR, 16'h0000);
        rd(OFS_RX_MAXP, 16'h0000);
        rd(OFS_RX_CSR, 16'h0000);
        wb(8'h14, 16'hffff, 4'h3, 1'b1);
        rd(8'h14, 16'h0000);
        wb(OFS_TX_CSR, 16'h3400, 4'h3, 1'b1);
        rd(OFS_TX_CSR, 16'h3400);
        chk_pin(dreq, 1);
        chk_pin(dir, 1);
        wb(OFS_TX_CSR, 16'h0100, 4'h3, 1'b1);
        rd(OFS_TX_CSR, 16'h0000);
        wb(OFS_TX_CSR, 16'h0300, 4'h3, 1'b1);
        rd(OFS_TX_CSR, 16'h0100);
        wb(OFS_TX_CSR, 16'h0040, 4'h1, 1'b1);
        rd(OFS_TX_CSR, 16'h0000);
        wb(OFS_TX_CSR, 16'h0800, 4'h3, 1'b1);
        rd(OFS_TX_CSR, 16'h0100);
        wb(OFS_EP_CFG, 16'h0006, 4'h3, 1'b1);
        wb(OFS_TX_CSR, 16'h0001, 4'h1, 1'b1);
        rd(OFS_TX_CSR, 16'h0103);
        chk_pin(start, 0);
        wb(OFS_EP_CFG, 16'h0002, 4'h3, 1'b1);
        rd(OFS_EP_CFG, 16'h0002);
        chk_pin(start, 1);
        i0 = n_irq;
        usb(2'd0, 4'h1, 1'b1);
        rd(OFS_TX_CSR, 16'h0000);
        chk_pin(n_irq, i0 + 1);
        wb(OFS_TX_CSR, 16'h0300, 4'h3, 1'b1);
        wb(OFS_TX_CSR, 16'h0011, 4'h1, 1'b1);
        rd(OFS_TX_CSR, 16'h0013);
        chk_pin(setup, 1);
        usb(2'd0, 4'h1, 1'b0);
        rd(OFS_TX_CSR, 16'h0100);
        p0 = n_prst;
        wb(OFS_TX_CSR, 16'h0008, 4'h1, 1'b1);
        rd(OFS_TX_CSR, 16'h0100);
        chk_pin(n_prst, p0);
        wb(OFS_TX_CSR, 16'h0001, 4'h1, 1'b1);
        wb(OFS_TX_CSR, 16'h0008, 4'h1, 1'b1);
        rd(OFS_TX_CSR, 16'h0100);
        chk_pin(n_prst, p0 + 1);
        wb(OFS_TX_CSR, 16'h0001, 4'h1, 1'b1);
        usb(2'd3, 4'h1, 1'b0);
        rd(OFS_TX_CSR, 16'h0120);
        wb(OFS_TX_CSR, 16'h0000, 4'h1, 1'b1);
        rd(OFS_TX_CSR, 16'h0100);
        i0 = n_irq;
        wb(OFS_TX_CSR, 16'h0001, 4'h1, 1'b1);
        usb(2'd2, 4'h3, 1'b1);
        rd(OFS_TX_CSR, 16'h0107);
        usb(2'd0, 4'h1, 1'b0);
        rd(OFS_TX_CSR, 16'h0004);
        chk_pin(n_irq, i0 + 2);
        wb(OFS_TX_CSR, 16'h0000, 4'h1, 1'b1);
        wb(OFS_NAK_LIM, 16'h0003, 4'h3, 1'b1);
        wb(OFS_TX_CSR, 16'h0001, 4'h1, 1'b1);
        usb(2'd1, 4'h3, 1'b0);
        rd(OFS_TX_CSR, 16'h0083);
        chk_pin(start, 0);
        wb(OFS_TX_CSR, 16'h0000, 4'h1, 1'b1);
        rd(OFS_TX_CSR, 16'h0003);
        chk_pin(start, 1);
        usb(2'd0, 4'h1, 1'b0);
        wb(OFS_NAK_LIM, 16'h0000, 4'h3, 1'b1);
        wb(OFS_TX_CSR, 16'h1401, 4'h3, 1'b1);
        i0 = n_irq;
        usb(2'd0, 4'h1, 1'b1);
        rd(OFS_TX_CSR, 16'h1400);
        chk_pin(n_irq, i0);
        wb(OFS_TX_CSR, 16'h0000, 4'h3, 1'b1);
        rnd = lfsr(lfsr(rnd));
        lim = {1'b0, rnd[9:0]} + 11'h001;
        wb(OFS_RX_MAXP, {5'h00, lim}, 4'h3, 1'b1);
        rd(OFS_RX_MAXP, {5'h00, lim});
        pkt(lim + 11'h001);
        rd(OFS_RX_CSR, 16'h0000);
        chk_pin(n_ok + n_rxi, 0);
        pkt(lim);
        rd(OFS_RX_CSR, 16'h0001);
        chk_pin(n_ok, 1);
        chk_pin(n_rxi, 1);
        complete_run();
    end
endmodule

// File: utx_ep_ctrl.sv
// Host transmit endpoint control and status, with receive payload limit
// and device-role receive status. Top module with a Wishbone register port.
// Assumes the packet engine reports handshakes as one-cycle pulses on clk_i.
`timescale 1ns/1ps
module utx_ep_ctrl
    import utx_pkg::*;
#(
    parameter int NAK_W = 16,
    parameter int QUEUE_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic tx_ack_i,
    input wire logic tx_nak_i,
    input wire logic tx_no_hs_i,
    input wire logic tx_stall_i,
    input wire logic rx_pkt_i,
    input wire logic [PAYLOAD_W-1:0] rx_len_i,
    input wire logic rx_crc_err_i,
    input wire logic rx_store_fail_i,
    input wire logic rx_full_i,
    input wire logic rx_stall_sent_i,
    output logic tx_start_o,
    output logic tx_setup_o,
    output logic tx_toggle_o,
    output logic tx_dir_o,
    output logic tx_dma_req_o,
    output logic tx_ptr_rst_o,
    output logic tx_irq_o,
    output logic rx_len_ok_o,
    output logic rx_irq_o,
    output logic rx_nyet_o,
    output logic rx_stall_o,
    output logic rx_toggle_o,
    output logic rx_dma_req_o,
    output logic rx_ptr_rst_o
);
    localparam int CNT_W = $clog2(QUEUE_DEPTH + 1);
    typedef struct packed {
        logic mode, dma_en, dma_mode, tog_wren, toggle, nak_to, stall, setup, err, loaded;
        logic [CNT_W-1:0] pkt_cnt;
        logic [PAYLOAD_W-1:0] payload_limit;
        logic [NAK_W-1:0] nak_limit;
        logic [1:0] ep_type;
        logic shared, high_speed;
        logic rx_iso, rx_dma_en, nyet_sup, rx_dma_mode, rx_toggle;
        logic rx_stall_sent, rx_stall_req, rx_crc, rx_ovr, rx_wait;
        logic tx_start, tx_ptr_rst, rx_ptr_rst, tx_irq, rx_irq, rx_len_ok, rx_nyet;
    } utx_state_t;
    utx_state_t q_r;
    utx_state_t q_nxt;
    utx_reg_if rb ();
    logic nak_hit, strike_hit, nak_clr, strike_clr, is_bulk, is_bulk_int;

    ////////////////////////////////////////////////////////////////////////
    // Bus front end and handshake counters

    utx_wb_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .dat_i(dat_i),
        .sel_i(sel_i),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .rb(rb)
    );

    assign is_bulk = (q_r.ep_type == EP_BULK);
    assign is_bulk_int = is_bulk || (q_r.ep_type == EP_INTR);
    // Counter restarts on any handshake that ends the NAK run
    assign nak_clr = tx_ack_i | tx_stall_i | nak_hit | ~is_bulk;
    assign strike_clr = tx_ack_i | tx_nak_i | tx_stall_i | strike_hit | ~is_bulk_int;

    utx_event_cnt #(.W(NAK_W)) u_nak_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(nak_clr),
        .inc_i(tx_nak_i),
        .limit_i(q_r.nak_limit),
        .hit_o(nak_hit)
    );

    utx_event_cnt #(.W(2)) u_strike_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(strike_clr),
        .inc_i(tx_no_hs_i),
        .limit_i(STRIKE_LIMIT),
        .hit_o(strike_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by read and write paths

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    always_comb begin
        rb.rdata = 16'h0000;
        if (hit(rb.addr, OFS_TX_CSR)) begin
            rb.rdata[TX_MODE] = q_r.mode;
            rb.rdata[TX_DMA_EN] = q_r.dma_en;
            rb.rdata[TX_DMA_MODE] = q_r.dma_mode;
            rb.rdata[TX_TOG] = q_r.toggle;
            rb.rdata[TX_NAK_TO] = q_r.nak_to;
            rb.rdata[TX_STALL] = q_r.stall;
            rb.rdata[TX_SETUP] = q_r.setup;
            rb.rdata[TX_ERR] = q_r.err;
            rb.rdata[TX_OCC] = (q_r.pkt_cnt != '0);
            rb.rdata[TX_LOADED] = q_r.loaded;
        end else if (hit(rb.addr, OFS_RX_MAXP)) begin
            rb.rdata[PAYLOAD_W-1:0] = q_r.payload_limit;
        end else if (hit(rb.addr, OFS_RX_CSR)) begin
            rb.rdata[RX_ISO] = q_r.rx_iso;
            rb.rdata[RX_DMA_EN] = q_r.rx_dma_en;
            rb.rdata[RX_NYET_SUP] = q_r.nyet_sup;
            rb.rdata[RX_DMA_MODE] = q_r.rx_dma_mode;
            rb.rdata[RX_STALL_SENT] = q_r.rx_stall_sent;
            rb.rdata[RX_STALL_REQ] = q_r.rx_stall_req;
            rb.rdata[RX_CRC_ERR] = q_r.rx_crc & q_r.rx_iso;
            rb.rdata[RX_OVERRUN] = q_r.rx_ovr & q_r.rx_iso;
            rb.rdata[RX_FULL] = rx_full_i;
            rb.rdata[RX_WAITING] = q_r.rx_wait;
        end else if (hit(rb.addr, OFS_NAK_LIM)) begin
            rb.rdata[NAK_W-1:0] = q_r.nak_limit;
        end else if (hit(rb.addr, OFS_EP_CFG)) begin
            rb.rdata[CFG_TYPE_LSB+1:CFG_TYPE_LSB] = q_r.ep_type;
            rb.rdata[CFG_SHARED] = q_r.shared;
            rb.rdata[CFG_HIGH_SPEED] = q_r.high_speed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: software writes first, link events after, so a
    // hardware set in the same cycle as a software clear wins

    always_comb begin
        logic [15:0] w;
        logic lo, hi, drop;
        w = rb.wdata;
        lo = rb.wr & rb.be[0];
        hi = rb.wr & rb.be[1];
        drop = 1'b0;
        q_nxt = q_r;
        q_nxt.tx_ptr_rst = 1'b0;
        q_nxt.rx_ptr_rst = 1'b0;
        q_nxt.tx_irq = 1'b0;
        q_nxt.rx_irq = 1'b0;
        q_nxt.rx_len_ok = 1'b0;

        if (hit(rb.addr, OFS_TX_CSR)) begin
            if (hi) begin
                q_nxt.mode = w[TX_MODE];
                q_nxt.dma_en = w[TX_DMA_EN];
                q_nxt.dma_mode = w[TX_DMA_MODE];
                if (q_r.tog_wren | w[TX_TOG_WREN]) begin
                    q_nxt.toggle = w[TX_TOG];
                    q_nxt.tog_wren = 1'b0;
                end
                if (w[TX_FORCE_TOG]) begin
                    q_nxt.toggle = ~q_nxt.toggle;
                    drop = 1'b1;
                end
            end
            if (lo) begin
                // Status flags clear on a zero write only
                q_nxt.nak_to = q_r.nak_to & w[TX_NAK_TO];
                q_nxt.stall = q_r.stall & w[TX_STALL];
                q_nxt.err = q_r.err & w[TX_ERR];
                q_nxt.setup = w[TX_SETUP];
                if (w[TX_SETUP] | w[TX_TOG_CLR]) begin
                    q_nxt.toggle = 1'b0;
                end
                if (w[TX_FLUSH] & q_r.loaded) begin
                    drop = 1'b1;
                end
                if (w[TX_LOADED] & ~q_r.loaded & (q_r.pkt_cnt < CNT_W'(QUEUE_DEPTH))) begin
                    q_nxt.loaded = 1'b1;
                    q_nxt.pkt_cnt = q_r.pkt_cnt + 1'b1;
                end
            end
        end

        if (hit(rb.addr, OFS_RX_CSR)) begin
            if (hi) begin
                q_nxt.rx_iso = w[RX_ISO];
                q_nxt.rx_dma_en = w[RX_DMA_EN];
                q_nxt.nyet_sup = w[RX_NYET_SUP];
                q_nxt.rx_dma_mode = w[RX_DMA_MODE];
            end
            if (lo) begin
                q_nxt.rx_toggle = q_r.rx_toggle & ~w[RX_TOG_CLR];
                q_nxt.rx_stall_sent = q_r.rx_stall_sent & w[RX_STALL_SENT];
                q_nxt.rx_stall_req = w[RX_STALL_REQ];
                q_nxt.rx_ovr = q_r.rx_ovr & w[RX_OVERRUN];
                q_nxt.rx_wait = q_r.rx_wait & w[RX_WAITING];
                if (w[RX_FLUSH] & q_r.rx_wait) begin
                    q_nxt.rx_wait = 1'b0;
                    q_nxt.rx_ptr_rst = 1'b1;
                end
            end
        end

        if (hit(rb.addr, OFS_RX_MAXP) && lo) begin
            q_nxt.payload_limit[7:0] = w[7:0];
        end
        if (hit(rb.addr, OFS_RX_MAXP) && hi) begin
            q_nxt.payload_limit[PAYLOAD_W-1:8] = w[PAYLOAD_W-1:8];
        end
        if (hit(rb.addr, OFS_NAK_LIM)) begin
            if (lo) begin
                q_nxt.nak_limit[7:0] = w[7:0];
            end
            if (hi) begin
                q_nxt.nak_limit[NAK_W-1:8] = w[NAK_W-1:8];
            end
        end
        if (hit(rb.addr, OFS_EP_CFG) && lo) begin
            q_nxt.ep_type = w[CFG_TYPE_LSB+1:CFG_TYPE_LSB];
            q_nxt.shared = w[CFG_SHARED];
            q_nxt.high_speed = w[CFG_HIGH_SPEED];
        end

        // Acknowledged transmit completes the loaded packet
        if (tx_ack_i & q_r.tx_start) begin
            q_nxt.toggle = ~q_nxt.toggle;
            q_nxt.setup = 1'b0;
            drop = 1'b1;
            q_nxt.tx_irq = ~(q_r.dma_en & q_r.dma_mode);
        end
        if (drop && (q_nxt.pkt_cnt != '0)) begin
            q_nxt.pkt_cnt = q_nxt.pkt_cnt - 1'b1;
        end
        if (drop) begin
            q_nxt.loaded = 1'b0;
            q_nxt.tx_ptr_rst = ~tx_ack_i;
        end
        if (nak_hit) begin
            q_nxt.nak_to = 1'b1;
        end
        if (strike_hit) begin
            q_nxt.err = 1'b1;
            q_nxt.tx_irq = 1'b1;
        end
        if (tx_stall_i) begin
            q_nxt.stall = 1'b1;
            q_nxt.loaded = 1'b0;
            q_nxt.pkt_cnt = '0;
            q_nxt.tx_ptr_rst = 1'b1;
            q_nxt.tx_irq = 1'b1;
        end

        // Device-role receive side
        if (rx_pkt_i && (rx_len_i <= q_r.payload_limit)) begin
            q_nxt.rx_len_ok = 1'b1;
            q_nxt.rx_wait = 1'b1;
            q_nxt.rx_irq = 1'b1;
            q_nxt.rx_toggle = ~q_nxt.rx_toggle;
            q_nxt.rx_crc = rx_crc_err_i & q_r.rx_iso;
        end
        if (~q_nxt.rx_wait) begin
            q_nxt.rx_crc = 1'b0;
        end
        if (rx_store_fail_i & q_r.rx_iso) begin
            q_nxt.rx_ovr = 1'b1;
        end
        if (rx_stall_sent_i) begin
            q_nxt.rx_stall_sent = 1'b1;
        end
        // NYET is sent only at high speed with a full FIFO and no suppress
        q_nxt.rx_nyet = q_nxt.high_speed & ~q_nxt.nyet_sup & rx_full_i;

        // Halted or wrong-direction endpoints issue no tokens
        q_nxt.tx_start = q_nxt.loaded & ~q_nxt.nak_to & ~q_nxt.stall & (q_nxt.mode | ~q_nxt.shared);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= '0;
            q_r.payload_limit <= RST_MAXP;
            q_r.nak_limit <= NAK_W'(RST_NAK_LIMIT);
        end else begin
            q_r <= q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from state

    assign tx_start_o = q_r.tx_start;
    assign tx_setup_o = q_r.setup;
    assign tx_toggle_o = q_r.toggle;
    assign tx_dir_o = q_r.mode;
    assign tx_dma_req_o = q_r.dma_en;
    assign tx_ptr_rst_o = q_r.tx_ptr_rst;
    assign tx_irq_o = q_r.tx_irq;
    assign rx_len_ok_o = q_r.rx_len_ok;
    assign rx_irq_o = q_r.rx_irq;
    assign rx_nyet_o = q_r.rx_nyet;
    assign rx_stall_o = q_r.rx_stall_req;
    assign rx_toggle_o = q_r.rx_toggle;
    assign rx_dma_req_o = q_r.rx_dma_en;
    assign rx_ptr_rst_o = q_r.rx_ptr_rst;

endmodule

// File: utx_ep_ctrl_monitor.sv
// Concurrent checks on the ports of the host transmit endpoint block.
// Assumes one clock and a synchronous active-high reset; bound below.
`timescale 1ns/1ps
module utx_ep_ctrl_monitor
    import utx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic ack_o,
    input wire logic tx_ack_i,
    input wire logic tx_stall_i,
    input wire logic rx_pkt_i,
    input wire logic [PAYLOAD_W-1:0] rx_len_i,
    input wire logic tx_start_o,
    input wire logic tx_toggle_o,
    input wire logic tx_dma_req_o,
    input wire logic tx_ptr_rst_o,
    input wire logic tx_irq_o,
    input wire logic rx_len_ok_o,
    input wire logic rx_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic wr_hi;
    logic dma_w_r;
    logic [10:0] lim_r;
    assign take = cyc_i && stb_i && !ack_o;
    assign wr_hi = take && we_i && adr_i == OFS_TX_CSR && sel_i[1];
    // Shadow of the payload limit so length checks need no internal access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lim_r <= RST_MAXP;
            dma_w_r <= 1'b0;
        end else begin
            if (take && we_i && adr_i == OFS_RX_MAXP && sel_i[0]) lim_r[7:0] <= dat_i[7:0];
            if (take && we_i && adr_i == OFS_RX_MAXP && sel_i[1]) lim_r[10:8] <= dat_i[10:8];
            if (wr_hi) dma_w_r <= dat_i[TX_DMA_EN];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_ack; take |=> ack_o ##1 !ack_o; endproperty
    property p_ack_cause; $rose(ack_o) |-> $past(take); endproperty
    // Three cycles: a next write, taken two cycles later at the earliest, also updates dma_w_r
    property p_dma; wr_hi |-> ##3 tx_dma_req_o == dma_w_r; endproperty
    property p_dma_hold; $changed(tx_dma_req_o) |-> $past(wr_hi) || $past(wr_hi, 2); endproperty
    property p_len_big; rx_pkt_i && rx_len_i > lim_r |=> !rx_len_ok_o && !rx_irq_o; endproperty
    property p_len_ok; rx_pkt_i && rx_len_i <= lim_r |=> rx_len_ok_o && rx_irq_o; endproperty
    property p_stall; tx_stall_i |=> tx_ptr_rst_o && !tx_start_o; endproperty
    property p_done; tx_ack_i && tx_start_o |=> !tx_start_o && tx_toggle_o != $past(tx_toggle_o); endproperty
    property p_irq; tx_ack_i && tx_start_o && !tx_dma_req_o |=> tx_irq_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_dma: assert property (p_dma) else $error("dma request differs from written bit");
    a_dma_hold: assert property (p_dma_hold) else $error("dma request moved without write");
    a_len_big: assert property (p_len_big) else $error("oversized packet accepted");
    a_len_ok: assert property (p_len_ok) else $error("packet within limit refused");
    a_stall: assert property (p_stall) else $error("stall did not flush");
    a_done: assert property (p_done) else $error("ack did not finish packet");
    a_irq: assert property (p_irq) else $error("no interrupt after packet");
    c_done: cover property (tx_ack_i && tx_start_o);
    c_stall: cover property (tx_stall_i);
    c_rx: cover property (rx_pkt_i ##1 rx_len_ok_o);
endmodule

bind utx_ep_ctrl utx_ep_ctrl_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o), .tx_ack_i(tx_ack_i),
    .tx_stall_i(tx_stall_i), .rx_pkt_i(rx_pkt_i), .rx_len_i(rx_len_i), .tx_start_o(tx_start_o),
    .tx_toggle_o(tx_toggle_o), .tx_dma_req_o(tx_dma_req_o), .tx_ptr_rst_o(tx_ptr_rst_o),
    .tx_irq_o(tx_irq_o), .rx_len_ok_o(rx_len_ok_o), .rx_irq_o(rx_irq_o));

// File: utx_event_cnt.sv
// Saturating event counter with a programmable threshold.
// Assumes inc and clr come from logic on the same clock.
`timescale 1ns/1ps
module utx_event_cnt #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic inc_i,
    input wire logic [W-1:0] limit_i,
    output logic hit_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } utx_cnt_state_t;

    utx_cnt_state_t q_r;
    utx_cnt_state_t q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (clr_i) begin
            q_nxt.cnt = '0;
        end else if (inc_i && (q_r.cnt != {W{1'b1}})) begin
            q_nxt.cnt = q_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // A zero limit disables the threshold
    assign hit_o = (limit_i != '0) && (q_r.cnt >= limit_i);

endmodule

// File: utx_func_model.sv
// Function device model: answers transmissions with handshake pulses.
// Assumes the bench arms it with a handshake kind and a count.
`timescale 1ns/1ps
module utx_func_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic go_i,
    input wire logic [1:0] kind_i,
    input wire logic [3:0] cnt_i,
    input wire logic slow_i,
    output logic [3:0] hs_o,
    output logic busy_o
);
    logic [3:0] left_r;
    logic [2:0] gap_r;
    assign busy_o = left_r != 4'h0;
    // Answers only while the host transmits, like a real function device
    always @(posedge clk_i) begin
        hs_o <= 4'h0;
        if (rst_i) begin
            left_r <= 4'h0;
            gap_r <= 3'h0;
        end else if (go_i) begin
            left_r <= cnt_i;
            gap_r <= 3'h0;
        end else if (busy_o && start_i) begin
            gap_r <= gap_r + 3'h1;
            if (gap_r == (slow_i ? 3'h4 : 3'h1)) begin
                hs_o[kind_i] <= 1'b1;
                left_r <= left_r - 4'h1;
                gap_r <= 3'h0;
            end
        end
    end
endmodule

// File: utx_pkg.sv
// Shared constants for the host transmit endpoint control block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package utx_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_TX_CSR = 8'h00;
    localparam logic [7:0] OFS_RX_MAXP = 8'h04;
    localparam logic [7:0] OFS_RX_CSR = 8'h08;
    localparam logic [7:0] OFS_NAK_LIM = 8'h0c;
    localparam logic [7:0] OFS_EP_CFG = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // Host transmit control/status bit positions
    localparam int TX_MODE = 13;
    localparam int TX_DMA_EN = 12;
    localparam int TX_FORCE_TOG = 11;
    localparam int TX_DMA_MODE = 10;
    localparam int TX_TOG_WREN = 9;
    localparam int TX_TOG = 8;
    localparam int TX_NAK_TO = 7;
    localparam int TX_TOG_CLR = 6;
    localparam int TX_STALL = 5;
    localparam int TX_SETUP = 4;
    localparam int TX_FLUSH = 3;
    localparam int TX_ERR = 2;
    localparam int TX_OCC = 1;
    localparam int TX_LOADED = 0;

    // Device receive control/status bit positions
    localparam int RX_ISO = 14;
    localparam int RX_DMA_EN = 13;
    localparam int RX_NYET_SUP = 12;
    localparam int RX_DMA_MODE = 11;
    localparam int RX_TOG_CLR = 7;
    localparam int RX_STALL_SENT = 6;
    localparam int RX_STALL_REQ = 5;
    localparam int RX_FLUSH = 4;
    localparam int RX_CRC_ERR = 3;
    localparam int RX_OVERRUN = 2;
    localparam int RX_FULL = 1;
    localparam int RX_WAITING = 0;

    // Endpoint configuration fields
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_SHARED = 2;
    localparam int CFG_HIGH_SPEED = 3;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset and fixed counts
    localparam logic [15:0] RST_NAK_LIMIT = 16'h0000;
    localparam logic [10:0] RST_MAXP = 11'h000;
    localparam logic [1:0] STRIKE_LIMIT = 2'h3;
    localparam int PAYLOAD_W = 11;

    typedef enum logic [1:0] {
        EP_CTRL = 2'b00,
        EP_ISO = 2'b01,
        EP_BULK = 2'b10,
        EP_INTR = 2'b11
    } utx_ep_type_t;

endpackage

// File: utx_reg_if.sv
// Register access carrier between the bus slave and the endpoint logic.
// Assumes one clock; write strobe is a single-cycle pulse.
`timescale 1ns/1ps
interface utx_reg_if;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic [15:0] rdata;

    modport bus (output wr, output addr, output wdata, output be, input rdata);
    modport regs (input wr, input addr, input wdata, input be, output rdata);
endinterface

// File: utx_wb_slave.sv
// Classic Wishbone slave front end for the endpoint registers.
// Assumes master holds the request until ack; every access is answered.
`timescale 1ns/1ps
module utx_wb_slave
    import utx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    utx_reg_if.bus rb
);

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } utx_wb_state_t;

    utx_wb_state_t q_r;
    utx_wb_state_t q_nxt;
    logic req;

    // One request per handshake: ack drops the cycle after it is given
    assign req = cyc_i & stb_i & ~q_r.ack;
    assign rb.wr = req & we_i;
    assign rb.addr = adr_i;
    assign rb.wdata = dat_i[15:0];
    assign rb.be = sel_i[1:0];

    always_comb begin
        q_nxt = q_r;
        q_nxt.ack = req;
        if (req & ~we_i) begin
            q_nxt.dat = {16'h0000, rb.rdata};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign ack_o = q_r.ack;
    assign dat_o = q_r.dat;

endmodule
